/* pkg/aord_pkg.sv */
package aord_pkg;
   // stream widths
   localparam int SAMPLE_W = 12;
   localparam int MAG_W = 11;
   localparam int FIELD_W = 8;
   localparam int FIELD_LSB = 3;
   localparam int EXP_W = 3;
   localparam int CNT_W = 8;
   localparam int NUM_FLAGS = 2;
   localparam int FLAG_HIGH = 0;
   localparam int FLAG_LOW = 1;
   localparam int TRIP_CNT_W = 16;
   // sample conversion
   localparam logic [SAMPLE_W-1:0] MIDSCALE_FLIP = 12'h800;
   localparam logic [MAG_W-1:0] MAG_MAX = 11'h7ff;
   // register bus
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_HIGH_THR = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_LOW_THR = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_WINDOW = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_TRIP_CNT = 8'h1c;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_RESTART_BIT = 1;
   // interrupt layout
   localparam int IRQ_W = 3;
   localparam int IRQ_HIGH_TRIP = 0;
   localparam int IRQ_LOW_TRIP = 1;
   localparam int IRQ_LOW_QUIET = 2;
   // reset values
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic [FIELD_W-1:0] HIGH_THR_RST = 8'hff;
   localparam logic [FIELD_W-1:0] LOW_THR_RST = 8'hff;
   localparam logic [EXP_W-1:0] WINDOW_RST = 3'h0;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
endpackage : aord_pkg

/* pkg/aord_win_if.sv */
`timescale 1ns/1ps
interface aord_win_if;
   logic sample_vld;
   logic [aord_pkg::FIELD_W-1:0] field;
   logic [aord_pkg::NUM_FLAGS-1:0][aord_pkg::FIELD_W-1:0] thr;
   logic [aord_pkg::EXP_W-1:0] exponent;
   logic restart;
   logic [aord_pkg::NUM_FLAGS-1:0] flags;
   logic done;

   // control side feeds samples and settings
   modport ctl (
      output sample_vld,
      output field,
      output thr,
      output exponent,
      output restart,
      input flags,
      input done
   );

   // monitor side returns window results
   modport mon (
      input sample_vld,
      input field,
      input thr,
      input exponent,
      input restart,
      output flags,
      output done
   );
endinterface : aord_win_if

/* verilog/aord_window_mon.sv */
`timescale 1ns/1ps
module aord_window_mon (
   input wire logic clk,
   input wire logic reset,
   aord_win_if.mon win
);
   logic [aord_pkg::CNT_W-1:0] cnt_ff;
   logic [aord_pkg::CNT_W-1:0] last_idx;
   logic win_end;
   logic done_ff;
   logic [aord_pkg::NUM_FLAGS-1:0] hit_ff;
   logic [aord_pkg::NUM_FLAGS-1:0] flags_ff;

   // window length is two to the exponent
   assign last_idx = (aord_pkg::CNT_W'(1) << win.exponent) - aord_pkg::CNT_W'(1); // RL5
   assign win_end = win.sample_vld && (cnt_ff == last_idx);

   ////////////////////////////////////////////////////////////////
   // sample position inside the current window
   always_ff @(posedge clk) begin
      if (reset || win.restart) begin
         cnt_ff <= '0;
      end else if (win.sample_vld) begin
         cnt_ff <= win_end ? '0 : cnt_ff + aord_pkg::CNT_W'(1); // RL10
      end
   end

   // one compare and latch per threshold
   for (genvar g = 0; g < aord_pkg::NUM_FLAGS; g++) begin : g_flag
      logic over;
      assign over = win.field >= win.thr[g]; // RL3

      // sticky hit within the open window
      always_ff @(posedge clk) begin
         if (reset || win.restart) begin
            hit_ff[g] <= 1'b0;
         end else if (win.sample_vld) begin
            hit_ff[g] <= win_end ? 1'b0 : (hit_ff[g] | over); // RL10
         end
      end

      // result held until the next window closes
      always_ff @(posedge clk) begin
         if (reset || win.restart) begin
            flags_ff[g] <= 1'b0;
         end else if (win_end) begin
            flags_ff[g] <= hit_ff[g] | over; // RL3
         end
      end
   end

   // pulse when a window result lands
   always_ff @(posedge clk) begin
      if (reset || win.restart) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= win_end;
      end
   end

   assign win.flags = flags_ff;
   assign win.done = done_ff;
endmodule : aord_window_mon

/* verilog/aord_top.sv */
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Function
// RL1: compare upper 8 magnitude bits, two thresholds
// RL2: offset binary to magnitude, negative saturates 2047
// RL3: flag set if field reaches threshold
// RL4: high threshold to I, low to Q
// RL5: window length is two to exponent
// RL6: I word: upper 15 bits plus flag
// RL7: Q word: upper 15 bits plus flag
// RL8: software sets high threshold near full scale
// RL9: receiver raises gain while low flag quiet
// RL10: back-to-back windows, results held, then cleared
module aord_top #(
   parameter int IQ_W = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [aord_pkg::SAMPLE_W-1:0] raw_sample,
   input wire logic raw_valid,
   input wire logic [IQ_W-1:0] i_in,
   input wire logic [IQ_W-1:0] q_in,
   input wire logic iq_valid,
   input wire logic [aord_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [aord_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [aord_pkg::DATA_W-1:0] reg_rdata,
   output logic [IQ_W-1:0] i_out,
   output logic [IQ_W-1:0] q_out,
   output logic iq_out_valid,
   output logic inphase_range_flag,
   output logic quadrature_range_flag,
   output logic irq
);

   ////////////////////////////////////////////////////////////////
   // declarations

   aord_win_if win ();

   logic enable_ff;
   logic restart_ff;
   logic [aord_pkg::FIELD_W-1:0] high_trip_threshold_ff;
   logic [aord_pkg::FIELD_W-1:0] low_trip_threshold_ff;
   logic [aord_pkg::EXP_W-1:0] monitor_window_exponent_ff;
   logic [aord_pkg::IRQ_W-1:0] irq_status_ff;
   logic [aord_pkg::IRQ_W-1:0] irq_mask_ff;
   logic [aord_pkg::IRQ_W-1:0] events;
   logic [aord_pkg::IRQ_W-1:0] status_clr;
   logic [aord_pkg::NUM_FLAGS-1:0][aord_pkg::TRIP_CNT_W-1:0] trip_cnt_ff;
   logic [aord_pkg::DATA_W-1:0] reg_rdata_ff;
   logic [aord_pkg::DATA_W-1:0] nxt_reg_rdata;

   logic wr_ctrl;
   logic wr_high;
   logic wr_low;
   logic wr_window;
   logic wr_status;
   logic wr_mask;
   logic wr_trip;

   logic [aord_pkg::SAMPLE_W-1:0] signed_sample;
   logic [aord_pkg::MAG_W-1:0] magnitude;
   logic [aord_pkg::FIELD_W-1:0] field_ff;
   logic field_vld_ff;

   logic [IQ_W-1:0] i_out_ff;
   logic [IQ_W-1:0] q_out_ff;
   logic iq_out_valid_ff;

   ////////////////////////////////////////////////////////////////
   // register write decode

   assign wr_ctrl = reg_wr && (reg_addr == aord_pkg::OFS_CTRL);
   assign wr_high = reg_wr && (reg_addr == aord_pkg::OFS_HIGH_THR);
   assign wr_low = reg_wr && (reg_addr == aord_pkg::OFS_LOW_THR);
   assign wr_window = reg_wr && (reg_addr == aord_pkg::OFS_WINDOW);
   assign wr_status = reg_wr && (reg_addr == aord_pkg::OFS_IRQ_STATUS);
   assign wr_mask = reg_wr && (reg_addr == aord_pkg::OFS_IRQ_MASK);
   assign wr_trip = reg_wr && (reg_addr == aord_pkg::OFS_TRIP_CNT);

   // enable bit
   always_ff @(posedge clk) begin
      if (reset) begin
         enable_ff <= aord_pkg::CTRL_EN_RST;
      end else if (wr_ctrl) begin
         enable_ff <= reg_wdata[aord_pkg::CTRL_EN_BIT];
      end
   end

   // restart pulse: explicit request, new window length, or disable
   always_ff @(posedge clk) begin
      if (reset) begin
         restart_ff <= 1'b1;
      end else begin
         restart_ff <= (wr_ctrl && reg_wdata[aord_pkg::CTRL_RESTART_BIT])
                       || (wr_ctrl && !reg_wdata[aord_pkg::CTRL_EN_BIT])
                       || wr_window;
      end
   end

   // high trip threshold
   always_ff @(posedge clk) begin
      if (reset) begin
         high_trip_threshold_ff <= aord_pkg::HIGH_THR_RST;
      end else if (wr_high) begin
         high_trip_threshold_ff <= reg_wdata[aord_pkg::FIELD_W-1:0];
      end
   end

   // low trip threshold
   always_ff @(posedge clk) begin
      if (reset) begin
         low_trip_threshold_ff <= aord_pkg::LOW_THR_RST;
      end else if (wr_low) begin
         low_trip_threshold_ff <= reg_wdata[aord_pkg::FIELD_W-1:0];
      end
   end

   // window exponent
   always_ff @(posedge clk) begin
      if (reset) begin
         monitor_window_exponent_ff <= aord_pkg::WINDOW_RST;
      end else if (wr_window) begin
         monitor_window_exponent_ff <= reg_wdata[aord_pkg::EXP_W-1:0]; // RL5
      end
   end

   // interrupt mask
   always_ff @(posedge clk) begin
      if (reset) begin
         irq_mask_ff <= aord_pkg::IRQ_MASK_RST;
      end else if (wr_mask) begin
         irq_mask_ff <= reg_wdata[aord_pkg::IRQ_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////
   // magnitude of the raw sample

   // flipping the top bit turns offset binary into two's complement
   assign signed_sample = raw_sample ^ aord_pkg::MIDSCALE_FLIP; // RL2

   // absolute value, most negative code saturates
   always_comb begin
      if (!signed_sample[aord_pkg::SAMPLE_W-1]) begin
         magnitude = signed_sample[aord_pkg::MAG_W-1:0];
      end else if (signed_sample[aord_pkg::MAG_W-1:0] == '0) begin
         magnitude = aord_pkg::MAG_MAX; // RL2
      end else begin
         magnitude = aord_pkg::MAG_W'(~signed_sample + aord_pkg::SAMPLE_W'(1)); // RL2
      end
   end

   // keep only the upper field bits of the magnitude
   always_ff @(posedge clk) begin
      if (reset) begin
         field_ff <= '0;
      end else if (raw_valid) begin
         field_ff <= magnitude[aord_pkg::MAG_W-1:aord_pkg::FIELD_LSB]; // RL1
      end
   end

   // every raw sample enters the monitor while enabled
   always_ff @(posedge clk) begin
      if (reset) begin
         field_vld_ff <= 1'b0;
      end else begin
         field_vld_ff <= raw_valid && enable_ff; // RL1
      end
   end

   ////////////////////////////////////////////////////////////////
   // window monitor

   assign win.sample_vld = field_vld_ff;
   assign win.field = field_ff;
   assign win.thr[aord_pkg::FLAG_HIGH] = high_trip_threshold_ff; // RL4
   assign win.thr[aord_pkg::FLAG_LOW] = low_trip_threshold_ff; // RL4
   assign win.exponent = monitor_window_exponent_ff;
   assign win.restart = restart_ff;

   aord_window_mon u_mon (
      .clk(clk),
      .reset(reset),
      .win(win.mon)
   );

   ////////////////////////////////////////////////////////////////
   // complex output words with embedded flags

   // in-phase word carries the high trip flag
   always_ff @(posedge clk) begin
      if (reset) begin
         i_out_ff <= '0;
      end else if (iq_valid) begin
         i_out_ff <= {i_in[IQ_W-1:1], win.flags[aord_pkg::FLAG_HIGH]}; // RL6
      end
   end

   // quadrature word carries the low trip flag
   always_ff @(posedge clk) begin
      if (reset) begin
         q_out_ff <= '0;
      end else if (iq_valid) begin
         q_out_ff <= {q_in[IQ_W-1:1], win.flags[aord_pkg::FLAG_LOW]}; // RL7
      end
   end

   // output valid follows input valid by one cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         iq_out_valid_ff <= 1'b0;
      end else begin
         iq_out_valid_ff <= iq_valid;
      end
   end

   assign i_out = i_out_ff;
   assign q_out = q_out_ff;
   assign iq_out_valid = iq_out_valid_ff;
   assign inphase_range_flag = win.flags[aord_pkg::FLAG_HIGH]; // RL4
   assign quadrature_range_flag = win.flags[aord_pkg::FLAG_LOW]; // RL4

   ////////////////////////////////////////////////////////////////
   // window statistics and interrupts

   // events at each closed window
   always_comb begin
      events = '0;
      events[aord_pkg::IRQ_HIGH_TRIP] = win.done && win.flags[aord_pkg::FLAG_HIGH];
      events[aord_pkg::IRQ_LOW_TRIP] = win.done && win.flags[aord_pkg::FLAG_LOW];
      events[aord_pkg::IRQ_LOW_QUIET] = win.done && !win.flags[aord_pkg::FLAG_LOW];
   end

   // write one to clear
   assign status_clr = wr_status ? reg_wdata[aord_pkg::IRQ_W-1:0] : '0;

   // sticky status, a new event beats a clear
   always_ff @(posedge clk) begin
      if (reset) begin
         irq_status_ff <= '0;
      end else begin
         irq_status_ff <= (irq_status_ff & ~status_clr) | events;
      end
   end

   // level interrupt from unmasked status
   assign irq = |(irq_status_ff & irq_mask_ff);

   // saturating count of tripped windows per flag
   for (genvar g = 0; g < aord_pkg::NUM_FLAGS; g++) begin : g_trip
      always_ff @(posedge clk) begin
         if (reset || wr_trip) begin
            trip_cnt_ff[g] <= '0;
         end else if (win.done && win.flags[g] && !(&trip_cnt_ff[g])) begin
            trip_cnt_ff[g] <= trip_cnt_ff[g] + aord_pkg::TRIP_CNT_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // register read

   // read mux, unmapped offsets return zero
   always_comb begin
      nxt_reg_rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            aord_pkg::OFS_CTRL: begin
               nxt_reg_rdata[aord_pkg::CTRL_EN_BIT] = enable_ff;
            end
            aord_pkg::OFS_HIGH_THR: begin
               nxt_reg_rdata[aord_pkg::FIELD_W-1:0] = high_trip_threshold_ff;
            end
            aord_pkg::OFS_LOW_THR: begin
               nxt_reg_rdata[aord_pkg::FIELD_W-1:0] = low_trip_threshold_ff;
            end
            aord_pkg::OFS_WINDOW: begin
               nxt_reg_rdata[aord_pkg::EXP_W-1:0] = monitor_window_exponent_ff;
            end
            aord_pkg::OFS_FLAGS: begin
               nxt_reg_rdata[aord_pkg::NUM_FLAGS-1:0] = win.flags;
            end
            aord_pkg::OFS_IRQ_STATUS: begin
               nxt_reg_rdata[aord_pkg::IRQ_W-1:0] = irq_status_ff;
            end
            aord_pkg::OFS_IRQ_MASK: begin
               nxt_reg_rdata[aord_pkg::IRQ_W-1:0] = irq_mask_ff;
            end
            aord_pkg::OFS_TRIP_CNT: begin
               nxt_reg_rdata = {trip_cnt_ff[aord_pkg::FLAG_LOW], trip_cnt_ff[aord_pkg::FLAG_HIGH]};
            end
            default: begin
               nxt_reg_rdata = '0;
            end
         endcase
      end
   end

   // read data stands for one cycle only
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata_ff <= '0;
      end else begin
         reg_rdata_ff <= nxt_reg_rdata;
      end
   end

   assign reg_rdata = reg_rdata_ff;
endmodule : aord_top

/* testbench/aord_top_assertions.sv */
`timescale 1ns/1ps
module aord_top_assertions #(
   parameter int IQ_W = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [aord_pkg::SAMPLE_W-1:0] raw_sample,
   input wire logic raw_valid,
   input wire logic [IQ_W-1:0] i_in,
   input wire logic [IQ_W-1:0] q_in,
   input wire logic iq_valid,
   input wire logic [aord_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [aord_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [aord_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [IQ_W-1:0] i_out,
   input wire logic [IQ_W-1:0] q_out,
   input wire logic iq_out_valid,
   input wire logic inphase_range_flag,
   input wire logic quadrature_range_flag,
   input wire logic irq
);
   logic [11:0] tc;
   logic [10:0] mag;
   logic [7:0] fld;
   logic en_ff;
   logic [7:0] hthr_ff;
   logic [7:0] lthr_ff;
   logic [2:0] exp_ff;
   logic win0;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////
   // magnitude field of the incoming sample
   always_comb begin
      tc = raw_sample ^ aord_pkg::MIDSCALE_FLIP;
      mag = tc[11] ? ((tc == 12'h800) ? aord_pkg::MAG_MAX : 11'(-tc)) : tc[10:0];
      fld = mag[10:3];
   end
   // shadow of the settings written by software
   always_ff @(posedge clk) begin
      if (reset) begin
         en_ff <= 1'b1;
         hthr_ff <= 8'hff;
         lthr_ff <= 8'hff;
         exp_ff <= 3'h0;
      end else if (reg_wr) begin
         if (reg_addr == aord_pkg::OFS_CTRL) en_ff <= reg_wdata[0];
         if (reg_addr == aord_pkg::OFS_HIGH_THR) hthr_ff <= reg_wdata[7:0];
         if (reg_addr == aord_pkg::OFS_LOW_THR) lthr_ff <= reg_wdata[7:0];
         if (reg_addr == aord_pkg::OFS_WINDOW) exp_ff <= reg_wdata[2:0];
      end
   end
   // single-sample window with no register traffic
   assign win0 = en_ff && exp_ff == 3'h0 && raw_valid && !reg_wr;
   ////////////////////////////////////////////////////////////////
   a_out_valid: assert property (iq_valid |=> iq_out_valid)
      else $error("output valid missing");
   a_i_word: assert property (iq_valid |=> (i_out >> 1) == ($past(i_in) >> 1) && i_out[0] == $past(inphase_range_flag))
      else $error("in-phase word wrong");
   a_q_word: assert property (iq_valid |=> (q_out >> 1) == ($past(q_in) >> 1) && q_out[0] == $past(quadrature_range_flag))
      else $error("quadrature word wrong");
   a_word_hold: assert property (!iq_valid |=> $stable(i_out) && $stable(q_out))
      else $error("output word moved");
   a_flag_idle: assert property ((!raw_valid && !reg_wr) [*4] |=> $stable(inphase_range_flag) && $stable(quadrature_range_flag))
      else $error("flag moved without samples");
   // sample taken at one edge shows on the flag two edges later
   a_high_trip: assert property (win0 && fld >= hthr_ff |-> ##2 inphase_range_flag)
      else $error("high flag not set");
   a_high_clear: assert property (win0 && fld < hthr_ff |-> ##2 !inphase_range_flag)
      else $error("high flag set wrongly");
   a_low_trip: assert property (win0 && fld >= lthr_ff |-> ##2 quadrature_range_flag)
      else $error("low flag not set");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
      else $error("read data without read");
endmodule : aord_top_assertions

bind aord_top aord_top_assertions #(.IQ_W(IQ_W)) u_chk (.clk(clk), .reset(reset), .raw_sample(raw_sample),
   .raw_valid(raw_valid), .i_in(i_in), .q_in(q_in), .iq_valid(iq_valid), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .i_out(i_out),
   .q_out(q_out), .iq_out_valid(iq_out_valid), .inphase_range_flag(inphase_range_flag),
   .quadrature_range_flag(quadrature_range_flag), .irq(irq));

/* testbench/aord_rx_model.sv */
`timescale 1ns/1ps
module aord_rx_model #(
   parameter int IQ_W = 16,
   parameter int QUIET_WORDS = 32
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [IQ_W-1:0] i_word,
   input wire logic [IQ_W-1:0] q_word,
   input wire logic word_valid,
   output logic gain_down,
   output logic gain_up
);
   logic [7:0] quiet_ff;
   ////////////////////////////////////////////////////////////////
   // high flag in the in-phase word asks for less gain
   always_ff @(posedge clk) begin
      if (reset) gain_down <= 1'b0;
      else if (word_valid) gain_down <= i_word[0];
   end
   // count words with the low flag quiet
   always_ff @(posedge clk) begin
      if (reset) quiet_ff <= 8'h00;
      else if (word_valid) quiet_ff <= q_word[0] ? 8'h00 : quiet_ff + 8'(quiet_ff != 8'hff);
   end
   assign gain_up = int'(quiet_ff) >= QUIET_WORDS;
endmodule : aord_rx_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic clk, reset, raw_valid, iq_valid, reg_wr, reg_rd, iq_out_valid, flag_i, flag_q, irq, gain_down, gain_up;
   logic [11:0] raw_sample;
   logic [15:0] i_in, q_in, i_out, q_out;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   int failures, checks, quiet;
   logic [11:0] corner [5] = '{12'hfff, 12'hff0, 12'h800, 12'h010, 12'h000};
   logic [7:0] cfield [5] = '{8'hff, 8'hfe, 8'h00, 8'hfe, 8'hff};
   aord_top dut (.clk(clk), .reset(reset), .raw_sample(raw_sample), .raw_valid(raw_valid), .i_in(i_in),
      .q_in(q_in), .iq_valid(iq_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .i_out(i_out), .q_out(q_out), .iq_out_valid(iq_out_valid),
      .inphase_range_flag(flag_i), .quadrature_range_flag(flag_q), .irq(irq));
   aord_rx_model rx (.clk(clk), .reset(reset), .i_word(i_out), .q_word(q_out), .word_valid(iq_out_valid),
      .gain_down(gain_down), .gain_up(gain_up));
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // expected magnitude field
   function automatic logic [7:0] fld(input logic [11:0] s);
      logic [11:0] t;
      t = s ^ 12'h800;
      if (t == 12'h800) return 8'hff;
      if (t[11]) t = -t;
      return t[10:3];
   endfunction : fld
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      cmp(reg_rdata & m, e, "read");
   endtask : rd
   task automatic samp(input logic [11:0] s, input logic v);
      @(posedge clk);
      raw_sample <= s;
      raw_valid <= v;
   endtask : samp
   // n valid samples with random gaps, loud one at pos, then settle
   task automatic burst(input int n, input int pos);
      int c;
      int g;
      logic v;
      c = 0;
      g = 0;
      while (c < n && g < 1000) begin
         v = 1'($urandom);
         samp((c == pos && v) ? 12'h000 : 12'h800, v);
         c += int'(v);
         g++;
      end
      // bounded stimulus loop
      if (c < n) begin
         failures++;
         $display("ERROR %0t burst limit", $time);
         final_report();
      end
      @(posedge clk);
      raw_valid <= 1'b0;
      repeat (5) @(posedge clk);
      @(negedge clk);
   endtask : burst
   // one word pair; expected flag bits come from the scenario
   task automatic iqw(input logic ei, input logic eq);
      @(posedge clk);
      i_in <= 16'($urandom);
      q_in <= 16'($urandom);
      iq_valid <= 1'b1;
      @(posedge clk);
      iq_valid <= 1'b0;
      @(negedge clk);
      cmp(i_out, {i_in[15:1], ei}, "i word");
      cmp(q_out, {q_in[15:1], eq}, "q word");
      @(negedge clk);
      quiet = eq ? 0 : quiet + 1;
      cmp(gain_down, ei, "gain down");
      cmp(gain_up, quiet >= 32, "gain up");
   endtask : iqw
   task automatic final_report();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////
   initial begin
      #500us;
      failures++;
      $display("ERROR %0t watchdog", $time);
      final_report();
   end
   // main sequence
   initial begin
      logic [11:0] s;
      logic [7:0] th, tl;
      logic ei, eq;
      failures = 0;
      checks = 0;
      quiet = 0;
      reset = 1'b1;
      {raw_valid, iq_valid, reg_wr, reg_rd, raw_sample, i_in, q_in, reg_addr, reg_wdata} = '0;
      void'($urandom(32'h0006));
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rd(aord_pkg::OFS_HIGH_THR, 32'hff, '1);
      rd(aord_pkg::OFS_WINDOW, 32'h0, '1);
      rd(8'h40, 32'h0, '1);
      // magnitude corners, then random one-sample windows
      for (int k = 0; k < 30; k++) begin
         s = k < 5 ? corner[k] : 12'($urandom);
         th = k < 5 ? cfield[k] + 8'(k % 2) : 8'($urandom);
         tl = 8'($urandom);
         wr(aord_pkg::OFS_HIGH_THR, {24'h0, th});
         wr(aord_pkg::OFS_LOW_THR, {24'h0, tl});
         samp(s, 1'b1);
         burst(0, -1);
         ei = (k < 5 ? cfield[k] : fld(s)) >= th;
         eq = fld(s) >= tl;
         cmp(flag_i, ei, "flag i");
         cmp(flag_q, eq, "flag q");
         iqw(ei, eq);
      end
      // every window length, boundary at one sample short
      wr(aord_pkg::OFS_HIGH_THR, 32'h80);
      wr(aord_pkg::OFS_LOW_THR, 32'hff);
      for (int e = 0; e < 8; e++) begin
         wr(aord_pkg::OFS_WINDOW, 32'(e));
         burst(1 << e, int'($urandom % (1 << e)));
         cmp({flag_q, flag_i}, 2'h3, "window trip");
         rd(aord_pkg::OFS_FLAGS, 32'h3, '1);
         burst((1 << e) - 1, -1);
         cmp(flag_i, 1'b1, "flag held");
         burst(1, -1);
         cmp(flag_i, 1'b0, "flag cleared");
         iqw(1'b0, 1'b0);
      end
      // disabled monitor ignores samples
      wr(aord_pkg::OFS_WINDOW, 32'h0);
      wr(aord_pkg::OFS_CTRL, 32'h0);
      burst(1, 0);
      cmp(flag_i, 1'b0, "disabled");
      wr(aord_pkg::OFS_CTRL, 32'h1);
      // interrupt masked, raised, cleared
      wr(aord_pkg::OFS_HIGH_THR, 32'he4);
      wr(aord_pkg::OFS_IRQ_STATUS, 32'h7);
      burst(1, 0);
      cmp(irq, 1'b0, "irq masked");
      rd(aord_pkg::OFS_IRQ_STATUS, 32'h1, 32'h1);
      wr(aord_pkg::OFS_IRQ_MASK, 32'h1);
      @(negedge clk);
      cmp(irq, 1'b1, "irq raised");
      wr(aord_pkg::OFS_IRQ_STATUS, 32'h1);
      @(negedge clk);
      cmp(irq, 1'b0, "irq cleared");
      rd(aord_pkg::OFS_IRQ_STATUS, 32'h2, 32'h7);
      // explicit restart drops a held flag
      cmp(flag_i, 1'b1, "flag armed");
      wr(aord_pkg::OFS_CTRL, 32'h3);
      repeat (2) @(negedge clk);
      cmp(flag_i, 1'b0, "restart");
      // quiet window on the low flag
      burst(1, -1);
      rd(aord_pkg::OFS_IRQ_STATUS, 32'h4, 32'h4);
      final_report();
   end
endmodule : tb_top
